//--- src/ebc_regs.svh
// ebc_regs.svh: register offsets, field positions and reset values
// of the external bus cycle controller; included by its design files.
//
// Functional notes
// - five phases in fixed order every cycle
// - phase lengths come from per-select timing registers
// - address setup one or two, up to five
// - changed window adds zero to three setup periods
// - command delay 0..3, access 1..32 periods
// - write setup or tristate phase 0 or 1
// - hold phase lasts 0..3 periods
// - enabled handshake stretches the access phase
// - inactive handshake inserts a wait, resamples
// - active handshake terminates the bus cycle
// - sync and async modes sample differently
// - minimum access periods pass before sampling
`ifndef EBC_REGS_SVH
`define EBC_REGS_SVH

// axi4-lite map, byte addresses
`define EBC_TCFG_BASE  8'h00
`define EBC_STAT_OFS   8'h40

// timing register fields
`define EBC_F_ASET     0
`define EBC_F_WEXT     2:1
`define EBC_F_CMD      4:3
`define EBC_F_WSET     5
`define EBC_F_ACC      10:6
`define EBC_F_HOLD     12:11
`define EBC_F_HSEN     13
`define EBC_F_HSASYNC  14
`define EBC_TCFG_MASK  16'h7FFF
`define EBC_TCFG_RST   16'h0000

// status register fields
`define EBC_S_PHASE    2:0
`define EBC_S_BUSY     3
`define EBC_S_CS       7:4
`define EBC_S_HSCNT    31:16

// axi responses
`define EBC_RESP_OKAY  2'h0
`define EBC_RESP_DEC   2'h3

`endif

//--- src/ebc_pkg.sv
// ebc_pkg: types of the external bus cycle controller.
// assumes nothing beyond a SystemVerilog compiler.
package ebc_pkg;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ADDR,
		PH_CMD,
		PH_WSET,
		PH_ACC,
		PH_HS,
		PH_HOLD
	} ebc_phase_e;

endpackage : ebc_pkg

//--- src/ebc_sync.sv
// ebc_sync: three-stage input synchroniser with agreement filter.
// assumes a level input from outside the aclk domain.
`timescale 1ns/1ps
module ebc_sync (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// level in and out
	input  wire logic din,
	output logic      dout
);
	logic [2:0] sh_q;
	logic [2:0] sh_d;
	logic       out_q;
	logic       out_d;

	// first stage feeds only the second
	always_comb
	begin
		sh_d  = {sh_q[1:0], din};
		out_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : out_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sh_q  <= 3'h0;
			out_q <= 1'b0;
		end
		else
		begin
			sh_q  <= sh_d;
			out_q <= out_d;
		end
	end

	assign dout = out_q;
endmodule : ebc_sync

//--- src/ebc_phase_cnt.sv
// ebc_phase_cnt: down counter that times one bus cycle phase.
// assumes load is a single-cycle pulse on phase entry.
`timescale 1ns/1ps
module ebc_phase_cnt #(
	parameter int W = 6
)(
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              last
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// one count per system clock period
	always_comb
	begin
		if (load)
			cnt_d = load_val;
		else if (cnt_q != '0)
			cnt_d = cnt_q - W'(1);
		else
			cnt_d = cnt_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	assign last = (cnt_q <= W'(1));
endmodule : ebc_phase_cnt

//--- src/ebc_bus_ctrl.sv
// ebc_bus_ctrl: external bus cycle sequencer with axi4-lite timing regs.
// assumes one aclk domain; ready pin is asynchronous, data pins are not.
`timescale 1ns/1ps
`include "ebc_regs.svh"
module ebc_bus_ctrl #(
	parameter int CSW = 2,
	parameter int AW  = 24,
	parameter int DW  = 16
)(
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite write
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// bus cycle request
	input  wire logic                 req_valid,
	output logic                      req_ready,
	input  wire logic                 req_write,
	input  wire logic [CSW-1:0]       req_cs,
	input  wire logic [AW-1:0]        req_addr,
	input  wire logic [DW-1:0]        req_wdata,
	output logic                      resp_valid,
	output logic [DW-1:0]             resp_rdata,
	// external bus pins
	output logic [AW-1:0]             bus_addr,
	output logic [(1<<CSW)-1:0]       bus_cs_n,
	output logic                      bus_rd_n,
	output logic                      bus_wr_n,
	output logic [DW-1:0]             bus_data_o,
	output logic                      bus_data_oe,
	input  wire logic [DW-1:0]        bus_data_i,
	input  wire logic                 bus_ready
);
	localparam int NCS = 1 << CSW;

	// register file
	logic [15:0]     tcfg_q [NCS];
	logic [15:0]     tcfg_d [NCS];
	logic            aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [7:0]      awa_q, awa_d;
	logic [15:0]     wd_q, wd_d;
	logic [1:0]      ws_q, ws_d, br_q, br_d, rr_q, rr_d;
	logic [31:0]     rd_q, rd_d;
	logic            wr_go;
	logic [31:0]     stat;

	// sequencer
	ebc_pkg::ebc_phase_e st_q, st_d;
	logic [CSW-1:0]  cs_q, cs_d, pcs_q, pcs_d;
	logic            pv_q, pv_d, wr_q, wr_d;
	logic [AW-1:0]   ad_q, ad_d;
	logic [DW-1:0]   wdt_q, wdt_d, rdt_q, rdt_d;
	logic [15:0]     cfg_q, cfg_d, hsc_q, hsc_d;
	logic [2:0]      alen_q, alen_d;
	logic            rsp_q, rsp_d, ld, cnt_last, hs_ok, fin;
	logic [5:0]      ld_val;
	ebc_pkg::ebc_phase_e end_ph;

	// pins
	logic [AW-1:0]   pa_q, pa_d;
	logic [NCS-1:0]  pcsn_q, pcsn_d;
	logic            prd_q, prd_d, pwr_q, pwr_d, poe_q, poe_d;
	logic [DW-1:0]   po_q, po_d;

	// write channel: aw and w taken in either order, one write at a time
	assign s_axi_awready = !aw_q && !bv_q;
	assign s_axi_wready  = !w_q && !bv_q;
	assign wr_go         = aw_q && w_q && !bv_q;

	always_comb
	begin
		aw_d  = aw_q;
		w_d   = w_q;
		awa_d = awa_q;
		wd_d  = wd_q;
		ws_d  = ws_q;
		bv_d  = bv_q;
		br_d  = br_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_d  = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_d  = 1'b1;
			wd_d = s_axi_wdata[15:0];
			ws_d = s_axi_wstrb[1:0];
		end
		if (wr_go)
		begin
			aw_d = 1'b0;
			w_d  = 1'b0;
			bv_d = 1'b1;
			if (awa_q[7:2] < 6'(NCS) || awa_q == `EBC_STAT_OFS)
				br_d = `EBC_RESP_OKAY;
			else
				br_d = `EBC_RESP_DEC;
		end
		else if (bv_q && s_axi_bready)
			bv_d = 1'b0;
	end

	// one timing register per chip select; status writes are ignored
	genvar gi;
	generate
		for (gi = 0; gi < NCS; gi++)
		begin : g_tcfg
			always_comb
			begin
				tcfg_d[gi] = tcfg_q[gi];
				if (wr_go && awa_q[7:2] == 6'(gi))
				begin
					if (ws_q[0])
						tcfg_d[gi][7:0] = wd_q[7:0];
					if (ws_q[1])
						tcfg_d[gi][15:8] = wd_q[15:8];
					tcfg_d[gi] = tcfg_d[gi] & `EBC_TCFG_MASK;
				end
			end

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					tcfg_q[gi] <= `EBC_TCFG_RST;
				else
					tcfg_q[gi] <= tcfg_d[gi];
			end
		end
	endgenerate

	// status word
	always_comb
	begin
		stat                 = 32'h0000_0000;
		stat[`EBC_S_PHASE]   = st_q;
		stat[`EBC_S_BUSY]    = (st_q != ebc_pkg::PH_IDLE);
		stat[`EBC_S_CS]      = 4'(cs_q);
		stat[`EBC_S_HSCNT]   = hsc_q;
	end

	// read channel: answer one cycle after the address is taken
	assign s_axi_arready = !rv_q;

	always_comb
	begin
		rv_d = rv_q;
		rd_d = rd_q;
		rr_d = rr_q;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rv_d = 1'b1;
			rr_d = `EBC_RESP_OKAY;
			if (s_axi_araddr == `EBC_STAT_OFS)
				rd_d = stat;
			else if (s_axi_araddr[7:2] < 6'(NCS))
				rd_d = {16'h0000, tcfg_q[s_axi_araddr[CSW+1:2]]};
			else
			begin
				rd_d = 32'h0000_0000;
				rr_d = `EBC_RESP_DEC;
			end
		end
		else if (rv_q && s_axi_rready)
			rv_d = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q  <= 1'b0;
			w_q   <= 1'b0;
			bv_q  <= 1'b0;
			rv_q  <= 1'b0;
			awa_q <= 8'h00;
			wd_q  <= 16'h0000;
			ws_q  <= 2'h0;
			br_q  <= 2'h0;
			rr_q  <= 2'h0;
			rd_q  <= 32'h0000_0000;
		end
		else
		begin
			aw_q  <= aw_d;
			w_q   <= w_d;
			bv_q  <= bv_d;
			rv_q  <= rv_d;
			awa_q <= awa_d;
			wd_q  <= wd_d;
			ws_q  <= ws_d;
			br_q  <= br_d;
			rr_q  <= rr_d;
			rd_q  <= rd_d;
		end
	end

	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp  = br_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rresp  = rr_q;
	assign s_axi_rdata  = rd_q;

	// ready pin crosses into aclk; costs four periods of latency
	ebc_sync u_rdy (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (bus_ready),
		.dout    (hs_ok)
	);

	ebc_phase_cnt #(.W(6)) u_cnt (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.load     (ld),
		.load_val (ld_val),
		.last     (cnt_last)
	);

	// sequencer; config is latched per cycle so software writes never
	// disturb a cycle in flight
	assign req_ready = (st_q == ebc_pkg::PH_IDLE);
	assign end_ph    = (cfg_q[`EBC_F_HOLD] != 2'h0) ? ebc_pkg::PH_HOLD
	                                                 : ebc_pkg::PH_IDLE;

	always_comb
	begin
		st_d   = st_q;
		cs_d   = cs_q;
		pcs_d  = pcs_q;
		pv_d   = pv_q;
		wr_d   = wr_q;
		ad_d   = ad_q;
		wdt_d  = wdt_q;
		rdt_d  = rdt_q;
		cfg_d  = cfg_q;
		alen_d = alen_q;
		hsc_d  = hsc_q;
		fin    = 1'b0;
		case (st_q)
			ebc_pkg::PH_IDLE:
				if (req_valid)
				begin
					st_d   = ebc_pkg::PH_ADDR;
					cs_d   = req_cs;
					wr_d   = req_write;
					ad_d   = req_addr;
					wdt_d  = req_wdata;
					cfg_d  = tcfg_q[req_cs];
					pcs_d  = req_cs;
					pv_d   = 1'b1;
					alen_d = 3'h1 + 3'(tcfg_q[req_cs][`EBC_F_ASET]);
					if (pv_q && pcs_q != req_cs)
						alen_d = alen_d + 3'(tcfg_q[req_cs][`EBC_F_WEXT]);
				end
			ebc_pkg::PH_ADDR:
				if (cnt_last)
				begin
					if (cfg_q[`EBC_F_CMD] != 2'h0)
						st_d = ebc_pkg::PH_CMD;
					else if (cfg_q[`EBC_F_WSET])
						st_d = ebc_pkg::PH_WSET;
					else
						st_d = ebc_pkg::PH_ACC;
				end
			ebc_pkg::PH_CMD:
				if (cnt_last)
					st_d = cfg_q[`EBC_F_WSET] ? ebc_pkg::PH_WSET : ebc_pkg::PH_ACC;
			ebc_pkg::PH_WSET:
				st_d = ebc_pkg::PH_ACC;
			ebc_pkg::PH_ACC:
				if (cnt_last)
				begin
					// async mode samples one period later than sync
					if (cfg_q[`EBC_F_HSEN] && (cfg_q[`EBC_F_HSASYNC] || !hs_ok))
						st_d = ebc_pkg::PH_HS;
					else
					begin
						st_d  = end_ph;
						rdt_d = bus_data_i;
					end
				end
			ebc_pkg::PH_HS:
			begin
				if (hs_ok)
				begin
					st_d  = end_ph;
					rdt_d = bus_data_i;
				end
			end
			ebc_pkg::PH_HOLD:
				if (cnt_last)
					st_d = ebc_pkg::PH_IDLE;
			default:
				st_d = ebc_pkg::PH_IDLE;
		endcase
		// every period spent in the wait phase counts, the first one too
		if (st_d == ebc_pkg::PH_HS && hsc_q != 16'hFFFF)
			hsc_d = hsc_q + 16'h0001;
		if (st_q != ebc_pkg::PH_IDLE && st_d == ebc_pkg::PH_IDLE)
			fin = 1'b1;
		rsp_d = fin;
	end

	// counter load on every phase entry
	always_comb
	begin
		ld     = (st_d != st_q);
		ld_val = 6'h01;
		case (st_d)
			ebc_pkg::PH_ADDR: ld_val = 6'(alen_d);
			ebc_pkg::PH_CMD:  ld_val = 6'(cfg_d[`EBC_F_CMD]);
			ebc_pkg::PH_ACC:  ld_val = 6'(cfg_d[`EBC_F_ACC]) + 6'h01;
			ebc_pkg::PH_HOLD: ld_val = 6'(cfg_d[`EBC_F_HOLD]);
			default:          ld_val = 6'h01;
		endcase
	end

	// pins follow the next phase so they come straight from flops
	always_comb
	begin
		pa_d   = (st_d == ebc_pkg::PH_IDLE) ? '0 : ad_d;
		pcsn_d = '1;
		if (st_d != ebc_pkg::PH_IDLE)
			pcsn_d[cs_d] = 1'b0;
		prd_d = !(!wr_d && (st_d == ebc_pkg::PH_ACC || st_d == ebc_pkg::PH_HS));
		pwr_d = !(wr_d && (st_d == ebc_pkg::PH_ACC || st_d == ebc_pkg::PH_HS));
		poe_d = wr_d && (st_d == ebc_pkg::PH_WSET || st_d == ebc_pkg::PH_ACC ||
		                 st_d == ebc_pkg::PH_HS || st_d == ebc_pkg::PH_HOLD);
		po_d  = poe_d ? wdt_d : '0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q   <= ebc_pkg::PH_IDLE;
			cs_q   <= '0;
			pcs_q  <= '0;
			pv_q   <= 1'b0;
			wr_q   <= 1'b0;
			ad_q   <= '0;
			wdt_q  <= '0;
			rdt_q  <= '0;
			cfg_q  <= 16'h0000;
			alen_q <= 3'h1;
			hsc_q  <= 16'h0000;
			rsp_q  <= 1'b0;
			pa_q   <= '0;
			pcsn_q <= '1;
			prd_q  <= 1'b1;
			pwr_q  <= 1'b1;
			poe_q  <= 1'b0;
			po_q   <= '0;
		end
		else
		begin
			st_q   <= st_d;
			cs_q   <= cs_d;
			pcs_q  <= pcs_d;
			pv_q   <= pv_d;
			wr_q   <= wr_d;
			ad_q   <= ad_d;
			wdt_q  <= wdt_d;
			rdt_q  <= rdt_d;
			cfg_q  <= cfg_d;
			alen_q <= alen_d;
			hsc_q  <= hsc_d;
			rsp_q  <= rsp_d;
			pa_q   <= pa_d;
			pcsn_q <= pcsn_d;
			prd_q  <= prd_d;
			pwr_q  <= pwr_d;
			poe_q  <= poe_d;
			po_q   <= po_d;
		end
	end

	assign resp_valid  = rsp_q;
	assign resp_rdata  = rdt_q;
	assign bus_addr    = pa_q;
	assign bus_cs_n    = pcsn_q;
	assign bus_rd_n    = prd_q;
	assign bus_wr_n    = pwr_q;
	assign bus_data_o  = po_q;
	assign bus_data_oe = poe_q;

	// cycles spent in the current phase, for checking only
	logic [5:0] run_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			run_q <= 6'h00;
		else
			run_q <= (st_d == st_q) ? run_q + 6'h01 : 6'h00;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_phase_order: assert property (
		st_q == ebc_pkg::PH_CMD |=>
		st_q inside {ebc_pkg::PH_CMD, ebc_pkg::PH_WSET, ebc_pkg::PH_ACC})
		else $error("command delay left to a wrong phase");
	a_addr_len: assert property (
		st_q == ebc_pkg::PH_ADDR && st_d != ebc_pkg::PH_ADDR |->
		run_q + 6'h01 == 6'(alen_q))
		else $error("address setup length wrong");
	a_window_ext: assert property (
		st_q == ebc_pkg::PH_IDLE && req_valid && pv_q && pcs_q != req_cs |=>
		alen_q == 3'h1 + 3'(cfg_q[`EBC_F_ASET]) + 3'(cfg_q[`EBC_F_WEXT]))
		else $error("window change extension missing");
	a_acc_len: assert property (
		st_q == ebc_pkg::PH_ACC && st_d != ebc_pkg::PH_ACC |->
		run_q == 6'(cfg_q[`EBC_F_ACC]))
		else $error("access phase length wrong");
	a_wset_one: assert property (
		st_q == ebc_pkg::PH_WSET |=> st_q == ebc_pkg::PH_ACC)
		else $error("write setup not one period");
	a_hold_len: assert property (
		st_q == ebc_pkg::PH_HOLD && st_d != ebc_pkg::PH_HOLD |->
		run_q + 6'h01 == 6'(cfg_q[`EBC_F_HOLD]))
		else $error("hold phase length wrong");
	a_hs_off: assert property (
		st_q == ebc_pkg::PH_ACC && cnt_last && !cfg_q[`EBC_F_HSEN] |=>
		st_q != ebc_pkg::PH_HS)
		else $error("wait inserted with handshake off");
	a_hs_wait: assert property (
		st_q == ebc_pkg::PH_HS && !hs_ok |=> st_q == ebc_pkg::PH_HS)
		else $error("inactive handshake did not wait");
	a_hs_end: assert property (
		st_q == ebc_pkg::PH_HS && hs_ok |=>
		st_q inside {ebc_pkg::PH_HOLD, ebc_pkg::PH_IDLE})
		else $error("active handshake did not end cycle");
	a_async_point: assert property (
		st_q == ebc_pkg::PH_ACC && cnt_last && cfg_q[`EBC_F_HSEN] &&
		cfg_q[`EBC_F_HSASYNC] |=> st_q == ebc_pkg::PH_HS)
		else $error("async handshake sampled too early");
	a_acc_min: assert property (
		st_q == ebc_pkg::PH_ACC && !cnt_last |=> st_q == ebc_pkg::PH_ACC)
		else $error("access phase cut short");
	a_resp_end: assert property (
		resp_valid |-> $past(st_q) != ebc_pkg::PH_IDLE && st_q == ebc_pkg::PH_IDLE)
		else $error("response without finished cycle");

	c_full_write: cover property (
		st_q == ebc_pkg::PH_WSET && wr_q ##[1:40] st_q == ebc_pkg::PH_HOLD);
	c_hs_wait: cover property (
		st_q == ebc_pkg::PH_HS ##1 st_q == ebc_pkg::PH_HS ##1 resp_valid);
	c_window: cover property (alen_q == 3'h5 && st_q == ebc_pkg::PH_ADDR);
endmodule : ebc_bus_ctrl

//--- dv/ebc_mem_model.sv
// ebc_mem_model: external memory on the parallel bus, with a ready delay.
// assumes the pins of ebc_bus_ctrl and a single aclk domain.
`timescale 1ns/1ps
module ebc_mem_model (
	// clock
	input  wire logic        aclk,
	// controller pins
	input  wire logic [23:0] bus_addr,
	input  wire logic [3:0]  bus_cs_n,
	input  wire logic        bus_rd_n,
	input  wire logic        bus_wr_n,
	input  wire logic [15:0] bus_data_o,
	input  wire logic        bus_data_oe,
	output logic [15:0]      bus_data_i,
	output logic             bus_ready,
	// test control
	input  wire logic [7:0]  rdy_dly
);
	logic [15:0] mem [16];
	logic [15:0] last_q;
	logic [7:0]  cnt_q;
	logic        sel;
	assign sel = ~&bus_cs_n;
	// released data bus toggles, so stale read data never passes
	assign bus_data_i = (sel && !bus_rd_n) ? mem[bus_addr[3:0]] : ~last_q;
	// ready held off rdy_dly periods of selection, low while idle
	assign bus_ready = sel && (cnt_q >= rdy_dly);
	initial
	begin
		last_q = 16'h0000;
		cnt_q = 8'h00;
		for (int i = 0; i < 16; i++)
			mem[i] = 16'hA500 + 16'(i);
	end
	always @(posedge aclk)
	begin
		last_q <= bus_data_i;
		cnt_q <= sel ? cnt_q + 8'h01 : 8'h00;
		if (sel && !bus_wr_n && bus_data_oe)
			mem[bus_addr[3:0]] <= bus_data_o;
	end
endmodule : ebc_mem_model

//--- dv/ebc_bus_ctrl_tb_top.sv
// ebc_bus_ctrl_tb_top: register and bus cycle tests of ebc_bus_ctrl.
// assumes default widths (2 select bits, 24 address, 16 data bits).
`timescale 1ns/1ps
`include "ebc_regs.svh"
module ebc_bus_ctrl_tb_top;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rdy_dly = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0, bus_cs_n;
	logic [1:0]  s_axi_bresp, s_axi_rresp, req_cs = 2'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, req_valid = 1'h0, req_write = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        req_ready, resp_valid, bus_rd_n, bus_wr_n, bus_data_oe, bus_ready;
	logic [23:0] req_addr = 24'h0, bus_addr;
	logic [15:0] req_wdata = 16'h0, resp_rdata, bus_data_o, bus_data_i;
	int          fail_count = 0;
	int          total_checks = 0;
	// columns: setup extra, window extra, command, write setup, access, hold
	int          phase_tab [4][6] = '{'{0, 0, 0, 0, 1, 0}, '{1, 3, 3, 1, 32, 3},
		'{0, 0, 1, 0, 2, 1}, '{1, 1, 2, 1, 5, 2}};

	initial
		forever #5 aclk = ~aclk;

	ebc_bus_ctrl dut_u (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_ready, .req_write,
		.req_cs, .req_addr, .req_wdata, .resp_valid, .resp_rdata, .bus_addr, .bus_cs_n,
		.bus_rd_n, .bus_wr_n, .bus_data_o, .bus_data_oe, .bus_data_i, .bus_ready
	);
	ebc_mem_model mem_u (
		.aclk, .bus_addr, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_data_o, .bus_data_oe,
		.bus_data_i, .bus_ready, .rdy_dly
	);

	task automatic finish_test;
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wait_fail;
		chk("handshake wait", 32'h0, 32'h1);
		finish_test();
	endtask : wait_fail

	function automatic logic [31:0] cfg(input int st, wx, cm, ws, ac, ho, he, hm);
		logic [31:0] v;
		v = 32'h0;
		v[`EBC_F_ASET] = st[0];
		v[`EBC_F_WEXT] = wx[1:0];
		v[`EBC_F_CMD] = cm[1:0];
		v[`EBC_F_WSET] = ws[0];
		v[`EBC_F_ACC] = 5'(ac - 1);
		v[`EBC_F_HOLD] = ho[1:0];
		v[`EBC_F_HSEN] = he[0];
		v[`EBC_F_HSASYNC] = hm[0];
		return v;
	endfunction : cfg

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
				break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (i == 50)
			wait_fail();
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid)
				break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		if (i == 50)
			wait_fail();
	endtask : axr

	// n counts edges from the take edge to the one that raises resp_valid
	task automatic cyc(input logic w, input logic [1:0] c, input logic [23:0] a,
		input logic [15:0] d, output int n);
		@(posedge aclk);
		req_write <= w;
		req_cs <= c;
		req_addr <= a;
		req_wdata <= d;
		req_valid <= 1'h1;
		@(posedge aclk);
		req_valid <= 1'h0;
		n = 0;
		do
		begin
			@(posedge aclk);
			#1;
			n++;
		end
		while (resp_valid !== 1'h1 && n < 200);
		if (n == 200)
			wait_fail();
	endtask : cyc

	// base length 7 here; every extra period must be a counted wait state
	task automatic hsrun(input logic [1:0] c, input logic [7:0] dl, input int lo, hi);
		logic [31:0] s0, s1;
		logic [1:0]  r;
		int          n;
		rdy_dly <= dl;
		axr(`EBC_STAT_OFS, s0, r);
		cyc(1'h0, c, 24'h5, 16'h0, n);
		axr(`EBC_STAT_OFS, s1, r);
		chk("hs length", (n >= lo && n <= hi), 32'h1);
		chk("hs waits", s1[31:16] - s0[31:16], 16'(n - 7));
	endtask : hsrun

	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		int          n, e;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		#1;
		chk("idle pins", {bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe, req_ready}, 8'hFD);
		axr(`EBC_TCFG_BASE, d, r);
		chk("tcfg0 reset", d, 32'h0);
		axr(`EBC_STAT_OFS, d, r);
		chk("status reset", d, 32'h0);
		axr(8'h80, d, r);
		chk("unmapped rresp", r, `EBC_RESP_DEC);
		axw(8'h80, 32'h1, 4'hF, r);
		chk("unmapped bresp", r, `EBC_RESP_DEC);
		axw(8'h0C, 32'hFFFFFFFF, 4'h1, r);
		axr(8'h0C, d, r);
		chk("tcfg3 low byte", d, 32'h000000FF);
		axw(8'h0C, 32'hFFFFFFFF, 4'hF, r);
		axr(8'h0C, d, r);
		chk("tcfg3 mask", d, 32'(`EBC_TCFG_MASK));
		axw(`EBC_STAT_OFS, 32'hFFFFFFFF, 4'hF, r);
		chk("status bresp", r, `EBC_RESP_OKAY);
		for (int k = 0; k < 4; k++)
		begin
			e = 1 + phase_tab[k][0] + phase_tab[k][2] + phase_tab[k][3] + phase_tab[k][4]
				+ phase_tab[k][5];
			axw(`EBC_TCFG_BASE, cfg(phase_tab[k][0], phase_tab[k][1], phase_tab[k][2],
				phase_tab[k][3], phase_tab[k][4], phase_tab[k][5], 0, 0), 4'hF, r);
			cyc(1'h1, 2'h0, 24'(k), 16'h1230 + 16'(k), n);
			chk("write length", n, e);
			cyc(1'h0, 2'h0, 24'(k), 16'h0, n);
			chk("read length", n, e);
			chk("read data", resp_rdata, 16'h1230 + 16'(k));
		end
		axw(8'h04, cfg(0, 2, 0, 0, 1, 0, 0, 0), 4'hF, r);
		cyc(1'h0, 2'h1, 24'h3, 16'h0, n);
		chk("window change", n, 4);
		cyc(1'h0, 2'h1, 24'h3, 16'h0, n);
		chk("same window", n, 2);
		cyc(1'h0, 2'h0, 24'h3, 16'h0, n);
		chk("window back", n, 13);
		chk("window data", resp_rdata, 16'h1233);
		axw(8'h08, cfg(1, 0, 3, 1, 1, 0, 1, 0), 4'hF, r);
		axw(8'h0C, cfg(1, 0, 3, 1, 1, 0, 1, 1), 4'hF, r);
		hsrun(2'h2, 8'h00, 7, 7);
		hsrun(2'h3, 8'h00, 8, 8);
		hsrun(2'h2, 8'h1E, 30, 42);
		hsrun(2'h3, 8'h1E, 30, 42);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		axr(8'h0C, d, r);
		chk("tcfg3 after reset", d, 32'h0);
		axr(`EBC_STAT_OFS, d, r);
		chk("status after reset", d, 32'h0);
		cyc(1'h0, 2'h3, 24'h5, 16'h0, n);
		chk("cycle after reset", n, 2);
		finish_test();
	end
endmodule : ebc_bus_ctrl_tb_top
